// file: design/psv_pkg.sv
// constants and types shared by the protection self-supervision block
package psv_pkg;

  // base clock and the millisecond time base
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // millisecond counters share one width
  typedef logic [10:0] psv_ms_t;

  // times in milliseconds, as set for this block
  localparam int SUP_PERIOD_MS = 1000;
  localparam int LINK_WINDOW_MS = 1200;
  localparam int BLINK_HALF_MS = 500;
  localparam int LOOP_PERIOD_MS = 100;

  // the same times as counts of millisecond ticks
  localparam psv_ms_t SUP_TICKS = psv_ms_t'(SUP_PERIOD_MS * 1000 / TICK_US);
  localparam psv_ms_t WIN_TICKS = psv_ms_t'(LINK_WINDOW_MS * 1000 / TICK_US);
  localparam psv_ms_t BLINK_TICKS =
    psv_ms_t'(BLINK_HALF_MS * 1000 / TICK_US);
  localparam psv_ms_t LOOP_TICKS =
    psv_ms_t'(LOOP_PERIOD_MS * 1000 / TICK_US);

  // configuration switch fields
  localparam int CFG_W = 8;
  localparam int CFG_LIGHT_ONLY_BIT = 0;
  localparam int CFG_BO_LIGHT_BIT = 1;
  localparam int CFG_MT_EN_BIT = 2;

  // auto-configuration sequence
  typedef enum logic [1:0] {
    PSV_UNCONF = 2'b00,
    PSV_SYNC = 2'b01,
    PSV_COUNT = 2'b10,
    PSV_RUN = 2'b11
  } psv_cfg_e;

endpackage : psv_pkg

// file: design/psv_top.sv
// self-supervision, indication and trip logic of the arc protection unit
`timescale 1ns/1ps

module psv_top
  import psv_pkg::*;
#(
  parameter int NUM_POINT = 14,
  parameter int NUM_LOOP = 1,
  parameter int NUM_BIN = 2,
  parameter int CNT_W = 4,
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // point sensors
  input wire logic [NUM_POINT-1:0] SENSOR_LIGHT,
  input wire logic [NUM_POINT-1:0] SENSOR_FAULT,
  // fiber loops
  output logic [NUM_LOOP-1:0] LOOP_TX,
  input wire logic [NUM_LOOP-1:0] LOOP_RX,
  // binary inputs from peer units
  input wire logic [NUM_BIN-1:0] BIN_PULSE,
  input wire logic OVERCURRENT_IN,
  input wire logic MASTER_TRIP_INPUT,
  // setup and front panel
  input wire logic [CFG_W-1:0] CFG_SW,
  input wire logic CONFIG_REQ,
  input wire logic SET_BTN,
  input wire logic SUPPLY_FAIL,
  // trip and signal outputs
  output logic [3:0] TRIP_RELAY,
  output logic FAST_TRIP_OUTPUT_A,
  output logic FAST_TRIP_OUTPUT_B,
  output logic LIGHT_BINARY_OUTPUT,
  output logic FAILURE_RELAY,
  // indicators
  output logic POWER_LED,
  output logic ERROR_LED,
  output logic [NUM_POINT+NUM_LOOP-1:0] CH_LED,
  output logic [NUM_BIN-1:0] BIN_LED,
  output logic TRIP_LED,
  output logic LIGHT_OUT_LED,
  output logic CONFIGURED
);

  localparam int NCH = NUM_POINT + NUM_LOOP;
  localparam int TCW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [TCW-1:0] tick_cnt;
    logic tick;
    psv_ms_t sec_cnt;
    psv_ms_t win_cnt;
    psv_ms_t blink_cnt;
    psv_ms_t loop_cnt;
    logic sup_p;
    logic blink;
    logic tx;
    logic [NUM_LOOP-1:0] seen;
    logic [NUM_LOOP-1:0] loop_fault;
    logic [NUM_BIN-1:0] bin_prev;
    logic [NUM_BIN-1:0][CNT_W-1:0] cnt;
    logic [NUM_BIN-1:0][CNT_W-1:0] ref_cnt;
    logic [NUM_BIN-1:0] mism;
    psv_cfg_e cfg_state;
    logic [CFG_W-1:0] cfg_req_sw;
    logic [CFG_W-1:0] cfg_sw;
    logic [NCH-1:0] ch_lat;
    logic [NUM_BIN-1:0] bin_lat;
    logic trip_lat;
    logic bo_lat;
    logic [3:0] o_trip;
    logic o_fast;
    logic o_light_bo;
    logic o_fail;
    logic o_err;
    logic o_pwr;
    logic [NCH-1:0] o_ch_led;
    logic [NUM_BIN-1:0] o_bin_led;
    logic o_trip_led;
    logic o_bo_led;
    logic o_cfg;
  } psv_state_s;

  psv_state_s st_r;
  psv_state_s st_nxt;

  // combinational terms; all but ch_light and win_end are watched by the checks below
  logic [NCH-1:0] ch_light;
  logic [NCH-1:0] ch_fault;
  logic [CFG_W-1:0] cfg_act;
  logic light_any;
  logic trip_cond;
  logic light_src;
  logic cfg_changed;
  logic error;
  logic win_end;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [NUM_BIN-1:0] edge_in;
    edge_in = BIN_PULSE & ~st_r.bin_prev;
    st_nxt = st_r;
    st_nxt.bin_prev = BIN_PULSE;
    // millisecond enable from the clock divider
    st_nxt.tick = (st_r.tick_cnt == TCW'(TICK_CYCLES - 1));
    st_nxt.tick_cnt = st_nxt.tick ? '0 : st_r.tick_cnt + 1'b1;
    win_end = st_r.tick && (st_r.win_cnt == WIN_TICKS - 1'b1);
    if (st_r.tx) st_nxt.seen = st_r.seen | LOOP_RX;

    if (st_r.tick) begin
      // one-tick supervision pulse each second
      st_nxt.sup_p = (st_r.sec_cnt == SUP_TICKS - 1'b1);
      st_nxt.sec_cnt = st_nxt.sup_p ? '0 : st_r.sec_cnt + 1'b1;
      st_nxt.win_cnt = win_end ? '0 : st_r.win_cnt + 1'b1;
      if (st_r.blink_cnt == BLINK_TICKS - 1'b1) begin
        st_nxt.blink_cnt = '0;
        st_nxt.blink = ~st_r.blink;
      end else begin
        st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
      end
      // loop test: send for one tick, judge at its end
      if (st_r.tx) begin
        st_nxt.tx = 1'b0;
        st_nxt.loop_fault = ~(st_r.seen | LOOP_RX);
      end else if (st_r.loop_cnt == LOOP_TICKS - 1'b1) begin
        st_nxt.tx = 1'b1;
        st_nxt.seen = '0;
      end
      st_nxt.loop_cnt = (st_r.loop_cnt == LOOP_TICKS - 1'b1) ?
                        '0 : st_r.loop_cnt + 1'b1;
    end
    // only the first second of a window counts: each peer lands once
    for (int i = 0; i < NUM_BIN; i++) begin
      if (win_end) begin
        st_nxt.cnt[i] = '0;
      end else if (edge_in[i] && st_r.win_cnt < SUP_TICKS) begin
        st_nxt.cnt[i] = sat_inc(st_r.cnt[i]);
      end
    end

    // auto-configuration; a full window is counted before storing
    case (st_r.cfg_state)
      PSV_SYNC: begin
        if (win_end) begin
          st_nxt.cfg_state = PSV_COUNT;
        end
      end
      PSV_COUNT: begin
        if (win_end) begin
          st_nxt.ref_cnt = st_r.cnt;
          st_nxt.cfg_sw = st_r.cfg_req_sw;
          st_nxt.mism = '0;
          st_nxt.cfg_state = PSV_RUN;
        end
      end
      PSV_UNCONF, PSV_RUN: begin
        if (win_end && st_r.cfg_state == PSV_RUN) begin
          for (int i = 0; i < NUM_BIN; i++) begin
            st_nxt.mism[i] = (st_r.cnt[i] != st_r.ref_cnt[i]);
          end
        end
      end
      default: st_nxt.cfg_state = PSV_UNCONF;
    endcase
    if (CONFIG_REQ) begin
      st_nxt.cfg_state = PSV_SYNC;
      st_nxt.cfg_req_sw = CFG_SW;
    end

    // stored switches rule once configured, live ones before
    cfg_act = (st_r.cfg_state == PSV_RUN) ? st_r.cfg_sw : CFG_SW;
    cfg_changed = (st_r.cfg_state == PSV_RUN) && (CFG_SW != st_r.cfg_sw);

    // faulty channels are blocked, the rest keep protecting
    ch_fault = {st_r.loop_fault, SENSOR_FAULT};
    ch_light = {LOOP_RX & ~{NUM_LOOP{st_r.tx}} & ~st_r.loop_fault,
                SENSOR_LIGHT & ~SENSOR_FAULT};
    light_any = |ch_light;
    trip_cond = (cfg_act[CFG_LIGHT_ONLY_BIT] ? light_any :
                 (light_any && OVERCURRENT_IN)) ||
                (cfg_act[CFG_MT_EN_BIT] && MASTER_TRIP_INPUT);
    light_src = cfg_act[CFG_BO_LIGHT_BIT] ? light_any : trip_cond;

    // latches: a new event wins over the set button
    st_nxt.ch_lat = ch_light | (st_r.ch_lat & {NCH{~SET_BTN}});
    st_nxt.bin_lat = {MASTER_TRIP_INPUT, OVERCURRENT_IN} |
                     (st_r.bin_lat & {NUM_BIN{~SET_BTN}});
    st_nxt.trip_lat = trip_cond || (st_r.trip_lat && !SET_BTN);
    st_nxt.bo_lat = light_src || (st_r.bo_lat && !SET_BTN);

    error = (|ch_fault) || (|st_r.mism) || cfg_changed || SUPPLY_FAIL;

    // registered outputs
    st_nxt.o_trip = {4{st_nxt.trip_lat}};
    st_nxt.o_fast = st_nxt.trip_lat || st_nxt.sup_p;
    st_nxt.o_light_bo = light_src || st_nxt.sup_p;
    st_nxt.o_fail = !error;
    st_nxt.o_err = error;
    st_nxt.o_pwr = !error;
    st_nxt.o_ch_led = (ch_fault & {NCH{st_nxt.blink}}) |
                      (~ch_fault & st_nxt.ch_lat);
    st_nxt.o_bin_led = (st_nxt.mism & {NUM_BIN{st_nxt.blink}}) |
                       (~st_nxt.mism & st_nxt.bin_lat);
    st_nxt.o_trip_led = st_nxt.trip_lat;
    st_nxt.o_bo_led = st_nxt.bo_lat;
    st_nxt.o_cfg = (st_nxt.cfg_state == PSV_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign LOOP_TX = {NUM_LOOP{st_r.tx}};
  assign TRIP_RELAY = st_r.o_trip;
  assign FAST_TRIP_OUTPUT_A = st_r.o_fast;
  assign FAST_TRIP_OUTPUT_B = st_r.o_fast;
  assign LIGHT_BINARY_OUTPUT = st_r.o_light_bo;
  assign FAILURE_RELAY = st_r.o_fail;
  assign POWER_LED = st_r.o_pwr;
  assign ERROR_LED = st_r.o_err;
  assign CH_LED = st_r.o_ch_led;
  assign BIN_LED = st_r.o_bin_led;
  assign TRIP_LED = st_r.o_trip_led;
  assign LIGHT_OUT_LED = st_r.o_bo_led;
  assign CONFIGURED = st_r.o_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_healthy_relay_on: assert property (
    @(posedge MCLK) disable iff (RST)
    !SUPPLY_FAIL && !(|ch_fault) && !(|st_r.mism) && !cfg_changed |=>
    POWER_LED && FAILURE_RELAY && !ERROR_LED)
    else $error("healthy state without power led or relay");

  chk_supply_fail_rel: assert property (
    @(posedge MCLK) disable iff (RST)
    SUPPLY_FAIL |=> !FAILURE_RELAY && ERROR_LED && !POWER_LED)
    else $error("supply failure did not release relay");

  chk_sensor_fault_err: assert property (
    @(posedge MCLK) disable iff (RST)
    SENSOR_FAULT[0] |=> ERROR_LED && !FAILURE_RELAY)
    else $error("sensor fault did not raise error");

  chk_fault_blocks_ch: assert property (
    @(posedge MCLK) disable iff (RST)
    $rose(st_r.ch_lat[0]) |-> $past(SENSOR_LIGHT[0] && !SENSOR_FAULT[0]))
    else $error("blocked channel latched light");

  chk_recover_auto: assert property (
    @(posedge MCLK) disable iff (RST)
    !error |=> !ERROR_LED && FAILURE_RELAY)
    else $error("no automatic recovery");

  chk_mismatch_error: assert property (
    @(posedge MCLK) disable iff (RST)
    (|st_r.mism) |=> ERROR_LED)
    else $error("peer count mismatch without error");

  chk_cfg_change_err: assert property (
    @(posedge MCLK) disable iff (RST)
    cfg_changed |=> ERROR_LED && $stable(st_r.cfg_sw))
    else $error("switch change not flagged or applied");

  chk_set_clears_trip: assert property (
    @(posedge MCLK) disable iff (RST)
    SET_BTN && !trip_cond |=> !TRIP_RELAY[0] && !TRIP_LED)
    else $error("set button did not clear trip");

  chk_bo_no_latch: assert property (
    @(posedge MCLK) disable iff (RST)
    !light_src && !st_nxt.sup_p |=> !LIGHT_BINARY_OUTPUT)
    else $error("light binary output latched");

  chk_light_cur_only: assert property (
    @(posedge MCLK) disable iff (RST)
    !cfg_act[CFG_LIGHT_ONLY_BIT] && !OVERCURRENT_IN && !MASTER_TRIP_INPUT &&
    !st_r.trip_lat |=> !TRIP_RELAY[0])
    else $error("trip without overcurrent");

  chk_light_only_trip: assert property (
    @(posedge MCLK) disable iff (RST)
    cfg_act[CFG_LIGHT_ONLY_BIT] && light_any |=> &TRIP_RELAY && TRIP_LED)
    else $error("light-only mode did not trip");

  chk_master_trip: assert property (
    @(posedge MCLK) disable iff (RST)
    cfg_act[CFG_MT_EN_BIT] && MASTER_TRIP_INPUT |=> TRIP_RELAY[0] &&
    FAST_TRIP_OUTPUT_A)
    else $error("master trip did not operate outputs");

  chk_bo_light_info: assert property (
    @(posedge MCLK) disable iff (RST)
    cfg_act[CFG_BO_LIGHT_BIT] && light_any |=> LIGHT_BINARY_OUTPUT)
    else $error("light info not on binary output");

  chk_sup_pulse: assert property (
    @(posedge MCLK) disable iff (RST)
    $rose(st_r.sup_p) |-> LIGHT_BINARY_OUTPUT && FAST_TRIP_OUTPUT_B)
    else $error("supervision pulse missing");

endmodule : psv_top

// file: verification/psv_far_side.sv
// far side model: fiber loop echo and peer units sending supervision pulses
`timescale 1ns/1ps
module psv_far_side
  import psv_pkg::*;
#(
  parameter int TC = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fiber loop
  input wire logic loop_tx,
  input wire logic loop_ok,
  output logic loop_rx,
  // peer units on each binary input
  input wire logic [1:0] peers_a,
  input wire logic [1:0] peers_b,
  output logic [1:0] bin_pulse
);
  int cyc;

  ////////////////////////////////////////////////////////////////////////////
  // a broken loop carries no light at all, so rx stays dark
  // light crosses the loop within the send cycle; a late echo would
  // look like arc light on the loop channel once sending stops
  always_comb begin
    loop_rx = loop_tx & loop_ok;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc <= 0;
    end else begin
      cyc <= (cyc + 1) % (int'(SUP_TICKS) * TC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // staggered offsets keep the edges of wired peers apart
  always_comb begin
    bin_pulse = 2'b00;
    for (int k = 0; k < 3; k++) begin
      if (cyc / TC == 100 * k + 10) begin
        bin_pulse[0] = bin_pulse[0] | (peers_a > k);
        bin_pulse[1] = bin_pulse[1] | (peers_b > k);
      end
    end
  end
endmodule : psv_far_side

// file: verification/psv_top_tb.sv
// self-checking bench of the protection self-supervision block
`timescale 1ns/1ps
module psv_top_tb;
  import psv_pkg::*;
  // short tick keeps the second-long windows affordable
  localparam int TC = 5;
  logic mclk = 0, rst = 1, oc = 0, mt = 0, cfg_req = 0, set_btn = 0;
  logic sup_fail = 0, loop_ok = 1;
  logic [13:0] light = '0, fault = '0;
  logic [7:0] cfg = 8'h01;
  logic [1:0] pa = 2'd1, pb = 2'd2, bin_pulse, bin_led;
  logic [0:0] loop_tx, loop_rx;
  logic [3:0] trip;
  logic fa, fb, lbo, fr, pwr, err, trip_led, lo_led, conf;
  logic [14:0] ch_led;
  int n_mismatch = 0, compares = 0, cycles = 0;

  psv_top #(.TICK_CYCLES(TC)) psv_top_inst (.MCLK(mclk), .RST(rst),
    .SENSOR_LIGHT(light), .SENSOR_FAULT(fault), .LOOP_TX(loop_tx),
    .LOOP_RX(loop_rx), .BIN_PULSE(bin_pulse), .OVERCURRENT_IN(oc),
    .MASTER_TRIP_INPUT(mt), .CFG_SW(cfg), .CONFIG_REQ(cfg_req),
    .SET_BTN(set_btn), .SUPPLY_FAIL(sup_fail), .TRIP_RELAY(trip),
    .FAST_TRIP_OUTPUT_A(fa), .FAST_TRIP_OUTPUT_B(fb),
    .LIGHT_BINARY_OUTPUT(lbo), .FAILURE_RELAY(fr), .POWER_LED(pwr),
    .ERROR_LED(err), .CH_LED(ch_led), .BIN_LED(bin_led),
    .TRIP_LED(trip_led), .LIGHT_OUT_LED(lo_led), .CONFIGURED(conf));
  psv_far_side #(.TC(TC)) psv_far_side_inst (.clk(mclk), .rst(rst),
    .loop_tx(loop_tx[0]), .loop_ok(loop_ok), .loop_rx(loop_rx[0]),
    .peers_a(pa), .peers_b(pb), .bin_pulse(bin_pulse));

  initial begin
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  function automatic logic pick(int sel);
    case (sel)
      0: return err;
      1: return conf;
      2: return fa;
      default: return loop_tx[0];
    endcase
  endfunction : pick

  task automatic wait_for(string what, int sel, logic v, int lim);
    int n = 0;
    while (pick(sel) !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(what, pick(sel), v);
  endtask : wait_for

  // two half periods must show at least two changes
  task automatic blink(string what, int sel, int idx);
    int n = 0;
    logic last;
    last = sel ? bin_led[idx] : ch_led[idx];
    repeat (2 * BLINK_TICKS * TC + 20) begin
      tick(1);
      if ((sel ? bin_led[idx] : ch_led[idx]) !== last) n++;
      last = sel ? bin_led[idx] : ch_led[idx];
    end
    chk(what, n > 1, 1);
  endtask : blink

  function automatic logic [3:0] exp_trip(logic [7:0] c, logic l, logic o,
                                          logic m);
    return (m & c[CFG_MT_EN_BIT]) | (l & (c[CFG_LIGHT_ONLY_BIT] | o)) ?
      4'hf : 4'h0;
  endfunction : exp_trip

  task automatic press_set();
    set_btn = 1;
    tick(1);
    set_btn = 0;
  endtask : press_set

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int ch;
    int c2;
    int h;
    logic l;
    logic o;
    logic m;
    logic tr;
    void'($urandom(32'h9708890b));
    tick(16);
    rst = 0;
    tick(2);
    chk("healthy", {fr, pwr, err}, 3'b110);
    wait_for("sup_pulse", 2, 1'b1, SUP_TICKS * TC + 20);
    chk("fast_b", fb, 1);
    tick(TC - 1);
    chk("pulse_high", fa, 1);
    tick(1);
    chk("pulse_end", fa, 0);
    // the next supervision pulse is far off, so quiet outputs are safe here
    for (int i = 0; i < 64; i++) begin
      cfg = 8'(i[2:0]);
      {l, o, m} = i[5:3];
      ch = $urandom_range(13);
      light[ch] = l;
      oc = o;
      mt = m;
      tick(1);
      tr = |exp_trip(cfg, l, o, m);
      chk("trip_relay", trip, exp_trip(cfg, l, o, m));
      chk("trip_led", trip_led, tr);
      chk("fast_a", fa, tr);
      chk("ch_led", ch_led[ch], l);
      chk("bin_led", bin_led, {m, o});
      chk("light_out", lbo, cfg[CFG_BO_LIGHT_BIT] ? l : tr);
      chk("light_led", lo_led, cfg[CFG_BO_LIGHT_BIT] ? l : tr);
      light = '0;
      oc = 0;
      mt = 0;
      tick(1);
      chk("light_out_off", lbo, 0);
      chk("trip_held", trip, exp_trip(cfg, l, o, m));
      press_set();
      chk("cleared", {trip, trip_led, lo_led, ch_led, bin_led}, 0);
    end
    cfg = 8'h01;
    sup_fail = 1;
    tick(1);
    chk("supply_fail", {fr, pwr, err}, 3'b001);
    sup_fail = 0;
    tick(1);
    chk("supply_back", {fr, pwr, err}, 3'b110);
    ch = $urandom_range(13);
    c2 = (ch + 1 + $urandom_range(12)) % 14;
    h = (c2 + 1) % 14;
    if (h == ch) h = (h + 1) % 14;
    fault[ch] = 1;
    fault[c2] = 1;
    light[ch] = 1;
    tick(1);
    chk("blocked", {fr, err, trip}, 6'b010000);
    light[h] = 1;
    tick(1);
    chk("healthy_trip", trip, 4'hf);
    light = '0;
    press_set();
    blink("sensor_blink", 0, ch);
    fault[ch] = 0;
    tick(2);
    chk("one_missing", {fr, err}, 2'b01);
    fault[c2] = 0;
    tick(2);
    chk("recovered", {fr, err, ch_led[ch], ch_led[c2]}, 4'b1000);
    wait_for("loop_tx", 3, 1'b1, LOOP_TICKS * TC + 20);
    loop_ok = 0;
    wait_for("loop_err", 0, 1'b1, 2 * LOOP_TICKS * TC + 20);
    chk("loop_relay", fr, 0);
    blink("loop_blink", 0, 14);
    loop_ok = 1;
    wait_for("loop_ok", 0, 1'b0, 2 * LOOP_TICKS * TC + 20);
    cfg_req = 1;
    tick(1);
    cfg_req = 0;
    wait_for("configured", 1, 1'b1, 2 * WIN_TICKS * TC + 100);
    chk("run_healthy", err, 0);
    cfg = 8'h00;
    wait_for("switch_err", 0, 1'b1, 4);
    light[ch] = 1;
    tick(1);
    chk("stored_mode", trip, 4'hf);
    light = '0;
    press_set();
    cfg = 8'h01;
    wait_for("switch_back", 0, 1'b0, 4);
    pb = 2'd1;
    wait_for("peer_err", 0, 1'b1, 2 * WIN_TICKS * TC + 100);
    blink("peer_blink", 1, 1);
    pb = 2'd2;
    wait_for("peer_ok", 0, 1'b0, 2 * WIN_TICKS * TC + 100);
    report_and_stop();
  end
endmodule : psv_top_tb
